// File: cfg_pin_pkg.sv
package cfg_pin_pkg;

    // Timing of the initialization phase at the 40 MHz configuration clock.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int INIT_LOW_TIME_NS = 1000;
    localparam int INIT_LOW_CYCLES = (INIT_LOW_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INIT_CNT_W = 16;

    // Loader watchdog while reading the nonvolatile array.
    localparam int LOAD_TIMEOUT_CYCLES = 4000;

    // Memory clear walks every frame of the volatile array.
    localparam int FRAME_AW = 4;
    localparam logic [FRAME_AW-1:0] FRAME_LAST = 4'hF;
    localparam logic [7:0] FRAME_CLEAR = 8'h00;

    // Load source selection.
    localparam logic SRC_NV_ARRAY = 1'b0;
    localparam logic SRC_EXT_FLASH = 1'b1;

    // Error cause encodings.
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_CRC = 3'h1;
    localparam logic [2:0] ERR_CMD = 3'h2;
    localparam logic [2:0] ERR_TIMEOUT = 3'h3;
    localparam logic [2:0] ERR_NO_DONE = 3'h4;

    // Configuration phases.
    typedef enum logic [2:0] {
        PH_POR,
        PH_INIT,
        PH_WAIT_INIT,
        PH_LOAD,
        PH_WAKE_HOLD,
        PH_USER,
        PH_ERROR
    } phase_t;

    // Feature-row style persistence settings, steady while the block runs.
    typedef struct packed {
        logic erased;
        logic restart_en;
        logic init_en;
        logic done_en;
        logic slave_serial_cfg_port_keep;
        logic i2c_keep;
        logic master_serial_cfg_port_keep;
        logic load_src;
    } feature_t;

    // Progress and error reports from the bitstream engine.
    typedef struct packed {
        logic frame_valid;
        logic [7:0] frame_data;
        logic program_done;
        logic crc_error;
        logic cmd_error;
        logic nv_ack;
        logic mem_end;
    } load_evt_t;

    // Pin ownership: high means the port keeps its configuration function.
    typedef struct packed {
        logic scan_port;
        logic slave_serial_cfg_port_port;
        logic i2c_port;
        logic master_serial_cfg_port_port;
        logic restart_pin;
        logic init_pin;
        logic done_pin;
        logic prom_sel_pin;
    } port_own_t;

endpackage

// File: cfg_frame_mem.sv
`timescale 1ns/1ps
`default_nettype none

// Small model of the volatile configuration array with registered read data.
module cfg_frame_mem (
    input wire logic mclk_in,
    input wire logic ce_in,
    input wire logic we_in,
    input wire logic [cfg_pin_pkg::FRAME_AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);
    import cfg_pin_pkg::*;

    logic [7:0] mem_q [0:(1<<FRAME_AW)-1];
    logic [7:0] rdata_q;

    // No reset on the storage; clearing is done by the sequencer walking every frame.
    always_ff @(posedge mclk_in) begin
        if (ce_in) begin
            if (we_in) begin
                mem_q[addr_in] <= wdata_in;
            end
            rdata_q <= mem_q[addr_in];
        end
    end

    assign rdata_out = rdata_q;
endmodule

`default_nettype wire

// File: cfg_pin_seq.sv
`timescale 1ns/1ps
`default_nettype none

module cfg_pin_seq (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire cfg_pin_pkg::feature_t feature_in,
    input wire logic config_restart_n_in,
    output logic restart_pullup_out,
    input wire logic init_status_n_in,
    output logic init_status_n_out,
    output logic init_status_n_oe_out,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_out,
    input wire logic refresh_in,
    input wire logic scan_prog_busy_in,
    input wire cfg_pin_pkg::load_evt_t load_evt_in,
    output logic load_start_out,
    output logic load_src_out,
    output logic nv_read_out,
    output cfg_pin_pkg::port_own_t port_own_out,
    output logic [cfg_pin_pkg::FRAME_AW-1:0] frame_addr_out,
    output logic [7:0] frame_rdata_out,
    output logic done_flag_out,
    output logic user_mode_out,
    output logic config_error_out,
    output logic [2:0] error_cause_out,
    output cfg_pin_pkg::phase_t phase_out
);
    import cfg_pin_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State record.

    typedef struct packed {
        phase_t phase;
        logic rst_s1;
        logic rst_s2;
        logic rst_s3;
        logic [INIT_CNT_W-1:0] init_cnt;
        logic [FRAME_AW-1:0] frame;
        logic clear_done;
        logic [INIT_CNT_W-1:0] wdog;
        logic done_flag;
        logic [2:0] err_cause;
        logic init_drive;
        logic done_drive;
        logic start_pulse;
        logic [7:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Decoded restart conditions, the memory write port and its data path.
    // These are plain combinational helpers except mem_rdata, the array's registered read data; all state outside the array lives in s_q.
    logic restart_fall;
    logic restart_honoured;
    logic restart_low;
    logic init_pin_low;
    logic done_pin_low;
    logic mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] mem_wdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Restart input conditioning.

    // Only the second and third stages feed the edge detector, so a metastable
    // first stage never reaches decision logic.
    assign restart_fall = s_q.rst_s3 && !s_q.rst_s2;
    assign restart_low = !s_q.rst_s2;

    // Power-up honours the pin regardless of the persistence setting, and a scan
    // programming sequence masks it completely until that sequence ends.
    assign restart_honoured = !scan_prog_busy_in &&
        (feature_in.restart_en || feature_in.erased || s_q.phase == PH_POR ||
         s_q.phase == PH_INIT || s_q.phase == PH_WAIT_INIT);

    // The pull-up is on only while restart is enabled or the part is erased, not in the init phases alone.
    assign restart_pullup_out = feature_in.restart_en || feature_in.erased;

    // Pins observed as low only when the enabled function gives them meaning.
    assign init_pin_low = feature_in.init_en && !feature_in.erased && !init_status_n_in;
    assign done_pin_low = feature_in.done_en && !feature_in.erased && !done_in;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // One process computes the whole next record. Defaults hold every field but the synchroniser,
    // the start pulse and the read data, so a phase only names what it changes and nothing latches by accident.
    always_comb begin
        s_d = s_q;
        s_d.rst_s1 = config_restart_n_in;
        s_d.rst_s2 = s_q.rst_s1;
        s_d.rst_s3 = s_q.rst_s2;
        s_d.start_pulse = 1'b0;
        s_d.rdata = mem_rdata;
        mem_we = 1'b0;
        mem_wdata = FRAME_CLEAR;

        case (s_q.phase)
            PH_POR: begin
                // Power-on reset releases straight into initialization.
                s_d.phase = PH_INIT;
                s_d.init_cnt = '0;
                s_d.frame = '0;
                s_d.clear_done = 1'b0;
            end
            PH_INIT: begin
                // Clear one frame per cycle while the init-low window runs.
                s_d.init_drive = 1'b1;
                s_d.done_drive = 1'b1;
                s_d.done_flag = 1'b0;
                s_d.err_cause = ERR_NONE;
                if (!s_q.clear_done) begin
                    mem_we = 1'b1;
                    s_d.frame = s_q.frame + 1'b1;
                    s_d.clear_done = (s_q.frame == FRAME_LAST);
                end
                if (s_q.init_cnt != INIT_CNT_W'(INIT_LOW_CYCLES)) begin
                    s_d.init_cnt = s_q.init_cnt + 1'b1;
                end else if (s_q.clear_done && !(restart_low && restart_honoured)) begin
                    s_d.phase = PH_WAIT_INIT;
                    s_d.init_drive = 1'b0;
                end
            end
            PH_WAIT_INIT: begin
                // Chained devices hold the open-drain line low until all are ready.
                // The line is only read when the pin is enabled and programmed, so
                // a floating general-purpose pin can never stall the loader.
                if (!init_pin_low) begin
                    s_d.phase = PH_LOAD;
                    s_d.start_pulse = 1'b1;
                    s_d.wdog = '0;
                    s_d.frame = '0;
                end
            end
            PH_LOAD: begin
                // Frames arrive in order; the address wraps at the array end.
                if (load_evt_in.frame_valid) begin
                    mem_we = 1'b1;
                    mem_wdata = load_evt_in.frame_data;
                    s_d.frame = s_q.frame + 1'b1;
                end
                // The watchdog only runs for the on-chip array; an external flash
                // is paced by its own clock and has no answer to wait for.
                if (feature_in.load_src == SRC_NV_ARRAY && !load_evt_in.nv_ack) begin
                    s_d.wdog = s_q.wdog + 1'b1;
                end else begin
                    s_d.wdog = '0;
                end
                // Priority among simultaneous faults: CRC, command, timeout, end.
                if (load_evt_in.crc_error) begin
                    s_d.err_cause = ERR_CRC;
                end else if (load_evt_in.cmd_error) begin
                    s_d.err_cause = ERR_CMD;
                end else if (s_q.wdog == INIT_CNT_W'(LOAD_TIMEOUT_CYCLES)) begin
                    s_d.err_cause = ERR_TIMEOUT;
                end else if (load_evt_in.mem_end && !load_evt_in.program_done) begin
                    s_d.err_cause = ERR_NO_DONE;
                end
                // A fault wins over a done command in the same cycle, so a bad
                // bitstream can never wake the device.
                if (s_d.err_cause != ERR_NONE) begin
                    s_d.phase = PH_ERROR;
                    s_d.init_drive = 1'b1;
                end else if (load_evt_in.program_done) begin
                    s_d.done_flag = 1'b1;
                    s_d.phase = PH_WAKE_HOLD;
                end
            end
            PH_WAKE_HOLD: begin
                // Release done, then wait while another agent still holds it low.
                s_d.done_drive = 1'b0;
                // The wait lasts one cycle at least, so the released line is read
                // only after our own driver has let go of it.
                if (!(feature_in.done_en && !feature_in.erased) ||
                    (!s_q.done_drive && !done_pin_low)) begin
                    s_d.phase = PH_USER;
                end
            end
            PH_USER: begin
                // Only restart or refresh leave user mode; see the override below.
                s_d.done_drive = 1'b0;
            end
            PH_ERROR: begin
                // Error state is sticky: no wake-up and done stays low.
                s_d.init_drive = 1'b1;
                s_d.done_drive = 1'b1;
                s_d.done_flag = 1'b0;
            end
            default: begin
                // An unused code restarts the whole sequence from power-on.
                s_d.phase = PH_POR;
            end
        endcase

        // Restart or refresh overrides every phase except the initial reset.
        // It comes last so that it beats any phase move made above.
        if (s_q.phase != PH_POR &&
            ((restart_fall && restart_honoured) || refresh_in)) begin
            s_d.phase = PH_INIT;
            s_d.init_cnt = '0;
            s_d.frame = '0;
            s_d.clear_done = 1'b0;
            s_d.init_drive = 1'b1;
            s_d.done_drive = 1'b1;
            s_d.done_flag = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // The synchroniser resets high so a released pin is not mistaken for an edge.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s_q <= '0;
            s_q.phase <= PH_POR;
            s_q.rst_s1 <= 1'b1;
            s_q.rst_s2 <= 1'b1;
            s_q.rst_s3 <= 1'b1;
            s_q.init_drive <= 1'b1;
            s_q.done_drive <= 1'b1;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Volatile configuration array.

    // The array shares the frame pointer with the clear walk and the loader,
    // so both write in ascending order from address zero.
    cfg_frame_mem u_frame_mem (
        .mclk_in(mclk_in),
        .ce_in(ce_in),
        .we_in(mem_we),
        .addr_in(s_q.frame),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    // Open-drain: the output value is always low and only the enable moves.
    // A disabled pin is never driven, so the board pull-up leaves it high.
    assign init_status_n_out = 1'b0;
    assign init_status_n_oe_out = s_q.init_drive && feature_in.init_en && !feature_in.erased;
    assign done_out = 1'b0;
    assign done_oe_out = s_q.done_drive && feature_in.done_en && !feature_in.erased;

    ////////////////////////////////////////////////////////////////////////////////
    // Port ownership.

    // Erased parts keep scan, slave serial and I2C for programming; a held restart
    // shuts the slave serial and I2C ports so a host cannot start too early.
    always_comb begin
        port_own_out = '0;
        port_own_out.scan_port = 1'b1;
        if (feature_in.erased) begin
            port_own_out.slave_serial_cfg_port_port = !restart_low;
            port_own_out.i2c_port = !restart_low;
            port_own_out.restart_pin = 1'b1;
        end else begin
            // Outside user mode the ports serve configuration; afterwards only kept ones.
            port_own_out.slave_serial_cfg_port_port = (s_q.phase != PH_USER) || feature_in.slave_serial_cfg_port_keep;
            port_own_out.i2c_port = (s_q.phase != PH_USER) || feature_in.i2c_keep;
            // The master port is only needed while loading from external flash.
            port_own_out.master_serial_cfg_port_port = (s_q.phase != PH_USER) ?
                (feature_in.load_src == SRC_EXT_FLASH) : feature_in.master_serial_cfg_port_keep;
            port_own_out.restart_pin = feature_in.restart_en;
            port_own_out.init_pin = feature_in.init_en;
            port_own_out.done_pin = feature_in.done_en;
            port_own_out.prom_sel_pin = port_own_out.master_serial_cfg_port_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status outputs.

    // Every status output is a register, a decode of the phase register or the steady feature setting,
    // so none of them glitches on a changing pin.
    assign load_start_out = s_q.start_pulse;
    assign load_src_out = feature_in.load_src;
    assign nv_read_out = (s_q.phase == PH_LOAD) && (feature_in.load_src == SRC_NV_ARRAY);
    assign frame_addr_out = s_q.frame;
    assign frame_rdata_out = s_q.rdata;
    assign done_flag_out = s_q.done_flag;
    assign user_mode_out = (s_q.phase == PH_USER);
    assign config_error_out = (s_q.phase == PH_ERROR);
    assign error_cause_out = s_q.err_cause;
    assign phase_out = s_q.phase;
endmodule

`default_nettype wire

// File: cfg_pin_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the control pin sequencer.
module cfg_pin_seq_properties (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire cfg_pin_pkg::feature_t feature_in,
    input wire logic config_restart_n_in,
    input wire logic init_status_n_in,
    input wire logic done_in,
    input wire logic refresh_in,
    input wire logic scan_prog_busy_in,
    input wire logic init_status_n_oe_out,
    input wire logic done_oe_out,
    input wire logic load_start_out,
    input wire cfg_pin_pkg::port_own_t port_own_out,
    input wire logic done_flag_out,
    input wire logic user_mode_out,
    input wire logic config_error_out,
    input wire cfg_pin_pkg::phase_t phase_out
);
    import cfg_pin_pkg::*;

    logic [15:0] init_cnt_q;
    logic pins_on;

    // Cycles spent in initialization; a count cut short means the init-low window was not held for its full time.
    always_ff @(posedge mclk_in) begin
        if (srst_in || phase_out != PH_INIT) begin
            init_cnt_q <= 16'h0000;
        end else begin
            init_cnt_q <= init_cnt_q + 16'h0001;
        end
    end

    // The status pins only act as configuration pins once the feature settings are programmed.
    assign pins_on = !feature_in.erased;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    //////////////////////////////////////////////////
    chk_init_full_time:
        assert property (phase_out == PH_INIT && init_cnt_q < INIT_LOW_CYCLES - 1
            |=> phase_out == PH_INIT)
            else $error("init phase too short");
    chk_init_hold_wait:
        assert property (phase_out == PH_WAIT_INIT && !init_status_n_in |=> phase_out != PH_LOAD)
            else $error("load began while init pin held low");
    chk_error_flags:
        assert property (config_error_out |-> !done_flag_out && !user_mode_out
            && (init_status_n_oe_out || !feature_in.init_en || !pins_on))
            else $error("error without init low or with done set");
    chk_error_latch:
        assert property (config_error_out |=> config_error_out || phase_out == PH_INIT)
            else $error("error dropped without initialization");
    chk_done_low:
        assert property (phase_out inside {PH_INIT, PH_WAIT_INIT, PH_LOAD, PH_ERROR}
            && pins_on && feature_in.done_en |-> done_oe_out)
            else $error("done pin released during configuration");
    chk_scan_mask:
        assert property ((scan_prog_busy_in && !refresh_in) [*5] ##0 phase_out == PH_USER
            |=> phase_out == PH_USER)
            else $error("restart honoured during scan programming");
    chk_done_stall:
        assert property (phase_out == PH_WAKE_HOLD && pins_on && feature_in.done_en && !done_in
            |=> phase_out != PH_USER)
            else $error("user mode entered while done pin held low");
    chk_load_pulse:
        assert property (load_start_out |-> init_status_n_in ##1 !load_start_out)
            else $error("load start not a single pulse with init high");
    chk_i2c_release:
        assert property (phase_out == PH_USER && pins_on && !feature_in.i2c_keep
            |-> !port_own_out.i2c_port)
            else $error("i2c pins kept in user mode");
    chk_erased_ports:
        assert property (feature_in.erased && config_restart_n_in [*4] |-> port_own_out.scan_port
            && port_own_out.slave_serial_cfg_port_port && port_own_out.i2c_port && port_own_out.restart_pin
            && !port_own_out.init_pin && !port_own_out.done_pin && !port_own_out.prom_sel_pin)
            else $error("erased state port ownership wrong");
    chk_init_hidden:
        assert property (!pins_on || !feature_in.init_en |-> !init_status_n_oe_out)
            else $error("init pin driven while disabled");

    cover property (phase_out == PH_USER);
    cover property (config_error_out);
    cover property (phase_out == PH_WAIT_INIT && !init_status_n_in);
endmodule

bind cfg_pin_seq cfg_pin_seq_properties chk_u (.*);

`default_nettype wire

// File: cfg_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// Board side of the control pins: pull-ups, open-drain wiring and host restart pulses.
module cfg_board_model #(
    parameter int RESTART_LOW = 8
) (
    input wire logic mclk_in,
    input wire logic pulse_in,
    input wire logic restart_hold_in,
    input wire logic init_hold_in,
    input wire logic done_hold_in,
    input wire logic init_oe_in,
    input wire logic done_oe_in,
    output logic restart_n_out,
    output logic init_n_out,
    output logic done_out
);
    int low_cnt = 0;

    // A pulse request is stretched to a fixed width, and one that arrives before the last ends is ignored.
    always @(posedge mclk_in) begin
        if (pulse_in && low_cnt == 0) begin
            low_cnt <= RESTART_LOW;
        end else if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
        end
    end

    // Released lines float to their pull-up level; any low driver wins.
    assign restart_n_out = !(restart_hold_in || low_cnt > 0);
    assign init_n_out = !(init_oe_in || init_hold_in);
    assign done_out = !(done_oe_in || done_hold_in);
    // The board drives none of the scan-port pins, so nothing contends with it.
endmodule

`default_nettype wire

// File: config_control_pin_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module config_control_pin_sequencer_tb;
    import cfg_pin_pkg::*;

    logic mclk_in = 1'h0, srst_in = 1'h1, ce_in = 1'h1, refresh_in = 1'h0;
    logic scan_prog_busy_in = 1'h0;
    logic config_restart_n_in, init_status_n_in, done_in, restart_pullup_out, init_status_n_out;
    logic init_status_n_oe_out, done_out, done_oe_out, load_start_out, load_src_out, nv_read_out;
    logic done_flag_out, user_mode_out, config_error_out;
    logic [2:0] error_cause_out;
    logic [FRAME_AW-1:0] frame_addr_out;
    logic [7:0] frame_rdata_out;
    feature_t feature_in = 8'h78;
    load_evt_t load_evt_in = '0;
    port_own_t port_own_out;
    phase_t phase_out;
    logic pulse = 1'h0, r_hold = 1'h0, i_hold = 1'h0, d_hold = 1'h0;
    logic [2:0] codes [4] = '{ERR_CRC, ERR_CMD, ERR_TIMEOUT, ERR_NO_DONE};
    logic [7:0] frames [$];
    int miscompares = 0;
    int tests_run = 0;

    cfg_pin_seq DUT (.*);
    cfg_board_model board (.mclk_in(mclk_in), .pulse_in(pulse), .restart_hold_in(r_hold),
        .init_hold_in(i_hold), .done_hold_in(d_hold), .init_oe_in(init_status_n_oe_out),
        .done_oe_in(done_oe_out), .restart_n_out(config_restart_n_in),
        .init_n_out(init_status_n_in), .done_out(done_in));

    // 40 MHz clock.
    initial begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    //////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Inputs change a fixed 2 ns after the edge so the design never races the bench.
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #2;
    endtask

    task automatic wait_ph(input phase_t p, input int lim);
        for (int i = 0; i < lim && phase_out !== p; i++) begin
            cyc(1);
        end
        if (phase_out !== p) begin
            chk("phase", phase_out, p);
            finish_test();
        end
    endtask

    task automatic restart();
        pulse = 1'h1;
        cyc(1);
        pulse = 1'h0;
    endtask

    // Random frames, then the closing event: 0 done, 1 crc, 2 cmd, 3 nothing, 4 memory end.
    task automatic load(input int n, input int k);
        wait_ph(PH_LOAD, 80);
        chk("nv read", nv_read_out, 1);
        chk("load src", load_src_out, SRC_NV_ARRAY);
        frames.delete();
        for (int i = 0; i < n; i++) begin
            load_evt_in = '0;
            load_evt_in.frame_valid = 1'h1;
            load_evt_in.frame_data = 8'($urandom);
            frames.push_back(load_evt_in.frame_data);
            load_evt_in.nv_ack = 1'h1;
            cyc(1);
        end
        load_evt_in = '0;
        load_evt_in.program_done = (k == 0);
        load_evt_in.crc_error = (k == 1);
        load_evt_in.cmd_error = (k == 2);
        load_evt_in.mem_end = (k == 4);
        cyc(1);
        load_evt_in = '0;
        // One address step per frame; read data lags two cycles and shows the last frame's cleared value from before its write, so it reads zero.
        chk("frame addr", frame_addr_out, 8'(frames.size()));
        chk("frame rdata", frame_rdata_out, 8'h00);
    endtask

    //////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hE11C));
        cyc(16);
        srst_in = 1'h0;
        wait_ph(PH_INIT, 3);
        chk("init oe", init_status_n_oe_out, 1);
        chk("done oe", done_oe_out, 1);
        chk("pull-up", restart_pullup_out, 1);
        i_hold = 1'h1;
        cyc(60);
        chk("held", phase_out, PH_WAIT_INIT);
        i_hold = 1'h0;
        d_hold = 1'h1;
        load(5, 0);
        wait_ph(PH_WAKE_HOLD, 5);
        chk("done flag", done_flag_out, 1);
        cyc(20);
        chk("stalled", user_mode_out, 0);
        d_hold = 1'h0;
        wait_ph(PH_USER, 10);
        chk("i2c own", port_own_out.i2c_port, 0);
        chk("slave_serial_cfg_port own", port_own_out.slave_serial_cfg_port_port, 1);
        chk("master_serial_cfg_port own", port_own_out.master_serial_cfg_port_port, 0);
        scan_prog_busy_in = 1'h1;
        restart();
        cyc(20);
        chk("masked", phase_out, PH_USER);
        scan_prog_busy_in = 1'h0;
        // Each failure cause in turn; the timeout case waits out the loader watchdog.
        for (int k = 0; k < 4; k++) begin
            restart();
            wait_ph(PH_INIT, 10);
            load(3, k + 1);
            wait_ph(PH_ERROR, LOAD_TIMEOUT_CYCLES + 100);
            chk("cause", error_cause_out, codes[k]);
            chk("err init oe", init_status_n_oe_out, 1);
            chk("err done oe", done_oe_out, 1);
            chk("err flag", done_flag_out, 0);
            cyc(10);
            chk("latched", config_error_out, 1);
        end
        restart();
        wait_ph(PH_LOAD, 80);
        cyc(2);
        restart();
        wait_ph(PH_INIT, 10);
        chk("err cleared", config_error_out, 0);
        load(4, 0);
        wait_ph(PH_USER, 10);
        refresh_in = 1'h1;
        cyc(1);
        refresh_in = 1'h0;
        wait_ph(PH_INIT, 3);
        chk("refresh done oe", done_oe_out, 1);
        srst_in = 1'h1;
        feature_in = 8'hF8;
        cyc(2);
        srst_in = 1'h0;
        cyc(10);
        chk("init hidden", init_status_n_oe_out, 0);
        chk("init reads", init_status_n_in, 1);
        chk("erased own", port_own_out & 8'hEF, 8'hE8);
        r_hold = 1'h1;
        cyc(60);
        chk("slave_serial_cfg_port off", port_own_out.slave_serial_cfg_port_port, 0);
        chk("i2c off", port_own_out.i2c_port, 0);
        chk("held init", phase_out, PH_INIT);
        r_hold = 1'h0;
        wait_ph(PH_LOAD, 80);
        finish_test();
    end
endmodule

`default_nettype wire
